// file: logic/identify_pkg.sv
/*
 * Shared constants for the identify parameter generator: word indices,
 * fixed word values, settings register offsets, reset values and states.
 * Assumes a 16-bit settings port on the same clock as the word stream.
 */
`default_nettype none
package identify_pkg;

    localparam int WORD_W = 16;
    localparam int IDX_W = 8;
    localparam int ADDR_W = 8;
    localparam int STR_WORDS = 34;
    localparam int STR_W = 6;

    localparam logic [IDX_W-1:0] LAST_IDX = 8'hFF;

    // Word positions inside the 256-word buffer.
    localparam logic [IDX_W-1:0] W_SPECCFG = 8'h02;
    localparam logic [IDX_W-1:0] W_HEADS = 8'h03;
    localparam logic [IDX_W-1:0] W_SPT = 8'h06;
    localparam logic [IDX_W-1:0] W_SER_FIRST = 8'h0A;
    localparam logic [IDX_W-1:0] W_SER_LAST = 8'h13;
    localparam logic [IDX_W-1:0] W_FW_FIRST = 8'h17;
    localparam logic [IDX_W-1:0] W_FW_LAST = 8'h1A;
    localparam logic [IDX_W-1:0] W_MOD_FIRST = 8'h1B;
    localparam logic [IDX_W-1:0] W_MOD_LAST = 8'h2E;
    localparam logic [IDX_W-1:0] W_MULT_MAX = 8'h2F;
    localparam logic [IDX_W-1:0] W_CAP49 = 8'h31;
    localparam logic [IDX_W-1:0] W_CAP50 = 8'h32;
    localparam logic [IDX_W-1:0] W_VALID = 8'h35;
    localparam logic [IDX_W-1:0] W_CUR_CYL = 8'h36;
    localparam logic [IDX_W-1:0] W_CUR_HEADS = 8'h37;
    localparam logic [IDX_W-1:0] W_CUR_SPT = 8'h38;
    localparam logic [IDX_W-1:0] W_CUR_CAP_LO = 8'h39;
    localparam logic [IDX_W-1:0] W_CUR_CAP_HI = 8'h3A;
    localparam logic [IDX_W-1:0] W_MULT_CUR = 8'h3B;
    localparam logic [IDX_W-1:0] W_LBA_LO = 8'h3C;
    localparam logic [IDX_W-1:0] W_LBA_HI = 8'h3D;
    localparam logic [IDX_W-1:0] W_MDMA = 8'h3F;
    localparam logic [IDX_W-1:0] W_PIO = 8'h40;
    localparam logic [IDX_W-1:0] W_CYC_FIRST = 8'h41;
    localparam logic [IDX_W-1:0] W_CYC_LAST = 8'h44;
    localparam logic [IDX_W-1:0] W_QDEPTH = 8'h4B;
    localparam logic [IDX_W-1:0] W_SATA_CAP = 8'h4C;
    localparam logic [IDX_W-1:0] W_SATA_SUP = 8'h4E;
    localparam logic [IDX_W-1:0] W_SATA_EN = 8'h4F;
    localparam logic [IDX_W-1:0] W_MAJOR = 8'h50;
    localparam logic [IDX_W-1:0] W_CMD82 = 8'h52;
    localparam logic [IDX_W-1:0] W_CMD83 = 8'h53;
    localparam logic [IDX_W-1:0] W_CMD84 = 8'h54;
    localparam logic [IDX_W-1:0] W_CMD85 = 8'h55;

    // String store slots: serial, then firmware, then model.
    localparam logic [STR_W-1:0] STR_SER_BASE = 6'h00;
    localparam logic [STR_W-1:0] STR_FW_BASE = 6'h0A;
    localparam logic [STR_W-1:0] STR_MOD_BASE = 6'h0E;

    // Fixed word values.
    localparam logic [WORD_W-1:0] V_SPECCFG = 16'hC837;
    localparam logic [WORD_W-1:0] V_HEADS = 16'h0010;
    localparam logic [WORD_W-1:0] V_SPT = 16'h003F;
    localparam logic [WORD_W-1:0] V_MULT_MAX = 16'h8010;
    localparam logic [WORD_W-1:0] V_CAP49 = 16'h2F00;
    localparam logic [WORD_W-1:0] V_CAP50 = 16'h4000;
    localparam logic [WORD_W-1:0] V_VALID = 16'h0007;
    localparam logic [WORD_W-1:0] V_MDMA_SUP = 16'h0007;
    localparam logic [WORD_W-1:0] V_PIO = 16'h0003;
    localparam logic [WORD_W-1:0] V_CYCLE = 16'h0078;
    localparam logic [WORD_W-1:0] V_QDEPTH = 16'h001F;
    localparam logic [WORD_W-1:0] V_SATA_CAP = 16'h0106;
    localparam logic [WORD_W-1:0] V_SATA_SUP = 16'h0044;
    localparam logic [WORD_W-1:0] V_MAJOR = 16'h01F0;
    localparam logic [WORD_W-1:0] V_CMD82 = 16'h746B;
    localparam logic [WORD_W-1:0] V_CMD83 = 16'h7D08;
    localparam logic [WORD_W-1:0] V_CMD84 = 16'h4040;
    localparam logic [WORD_W-1:0] V_CMD85_FIX = 16'h7468;
    localparam logic [WORD_W-1:0] V_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] V_SPACES = 16'h2020;

    // Writable masks of the settings registers.
    localparam logic [WORD_W-1:0] MULT_MASK = 16'h01FF;
    localparam logic [WORD_W-1:0] SATA_EN_MASK = 16'h0044;
    localparam logic [WORD_W-1:0] CMD85_EN_MASK = 16'h0003;
    localparam int MDMA_SEL_LSB = 8;

    // Settings register offsets.
    localparam logic [ADDR_W-1:0] R_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] R_CAP_LO = 8'h01;
    localparam logic [ADDR_W-1:0] R_CAP_HI = 8'h02;
    localparam logic [ADDR_W-1:0] R_MULT = 8'h03;
    localparam logic [ADDR_W-1:0] R_MDMA = 8'h04;
    localparam logic [ADDR_W-1:0] R_SATA_EN = 8'h05;
    localparam logic [ADDR_W-1:0] R_CMD85_EN = 8'h06;
    localparam logic [ADDR_W-1:0] R_CUR_CYL = 8'h07;
    localparam logic [ADDR_W-1:0] R_STR_BASE = 8'h40;

    // Reset values of the settings.
    localparam logic [31:0] CAP_RESET = 32'h001E_2190;
    localparam logic [WORD_W-1:0] CYL_RESET = 16'h07A7;
    localparam logic [WORD_W-1:0] MULT_RESET = 16'h0110;
    localparam logic [2:0] MDMA_RESET = 3'h0;
    localparam logic [WORD_W-1:0] SATA_EN_RESET = 16'h0040;
    localparam logic [WORD_W-1:0] CMD85_EN_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PREP = 2'b01,
        ST_XFER = 2'b10
    } xfer_state_e;

    // True when idx lies in [lo, hi].
    function automatic logic in_span(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] lo,
                                     input logic [IDX_W-1:0] hi);
        in_span = (idx >= lo) && (idx <= hi);
    endfunction

    // Keeps only the highest selected multiword DMA mode, so no more than one mode shows.
    function automatic logic [2:0] one_mode(input logic [2:0] sel);
        if (sel[2])
        begin
            one_mode = 3'b100;
        end
        else if (sel[1])
        begin
            one_mode = 3'b010;
        end
        else
        begin
            one_mode = sel & 3'b001;
        end
    endfunction

endpackage
`default_nettype wire

// file: logic/identify_word_map.sv
/*
 * Combinational map from a word index to the identify word value.
 * Assumes the settings and string store come from flip-flops of the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module identify_word_map (
    input wire logic [identify_pkg::IDX_W-1:0] idx,
    input wire logic [31:0] capacity,
    input wire logic [identify_pkg::WORD_W-1:0] cur_cyl,
    input wire logic [identify_pkg::WORD_W-1:0] mult,
    input wire logic [2:0] mdma_sel,
    input wire logic [identify_pkg::WORD_W-1:0] sata_en,
    input wire logic [identify_pkg::WORD_W-1:0] cmd85_en,
    input wire logic [identify_pkg::STR_WORDS-1:0][identify_pkg::WORD_W-1:0] str,
    output logic [identify_pkg::WORD_W-1:0] word
);
    import identify_pkg::*;

    logic [STR_W-1:0] slot;

    always_comb
    begin
        slot = '0;
        word = V_ZERO;
        if (in_span(idx, W_SER_FIRST, W_SER_LAST))
        begin
            slot = STR_SER_BASE + STR_W'(idx - W_SER_FIRST);
            word = str[slot];
        end
        else if (in_span(idx, W_FW_FIRST, W_FW_LAST))
        begin
            slot = STR_FW_BASE + STR_W'(idx - W_FW_FIRST);
            word = str[slot];
        end
        else if (in_span(idx, W_MOD_FIRST, W_MOD_LAST))
        begin
            slot = STR_MOD_BASE + STR_W'(idx - W_MOD_FIRST);
            word = str[slot];
        end
        else if (in_span(idx, W_CYC_FIRST, W_CYC_LAST))
        begin
            word = V_CYCLE;
        end
        else
        begin
            case (idx)
                W_SPECCFG: word = V_SPECCFG;
                W_HEADS: word = V_HEADS;
                W_SPT: word = V_SPT;
                W_MULT_MAX: word = V_MULT_MAX;
                W_CAP49: word = V_CAP49;
                W_CAP50: word = V_CAP50;
                W_VALID: word = V_VALID;
                W_CUR_CYL: word = cur_cyl;
                W_CUR_HEADS: word = V_HEADS;
                W_CUR_SPT: word = V_SPT;
                W_CUR_CAP_LO: word = capacity[15:0];
                W_CUR_CAP_HI: word = capacity[31:16];
                W_MULT_CUR: word = mult & MULT_MASK;
                W_LBA_LO: word = capacity[15:0];
                W_LBA_HI: word = capacity[31:16];
                W_MDMA: word = V_MDMA_SUP | (WORD_W'(mdma_sel) << MDMA_SEL_LSB);
                W_PIO: word = V_PIO;
                W_QDEPTH: word = V_QDEPTH;
                W_SATA_CAP: word = V_SATA_CAP;
                W_SATA_SUP: word = V_SATA_SUP;
                W_SATA_EN: word = sata_en & SATA_EN_MASK;
                W_MAJOR: word = V_MAJOR;
                W_CMD82: word = V_CMD82;
                W_CMD83: word = V_CMD83;
                W_CMD84: word = V_CMD84;
                W_CMD85: word = V_CMD85_FIX | (cmd85_en & CMD85_EN_MASK);
                default: word = V_ZERO;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: logic/identify_data_table.sv
/*
 * Identify parameter generator: settings registers, string store and the
 * 256-word read-out sequencer that answers an identify command.
 * Assumes the command logic and host data path share ref_clk and pulse
 * start and word reads for one cycle each.
 */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module identify_data_table #(
    parameter logic [31:0] CAP_DEFAULT = identify_pkg::CAP_RESET,
    parameter logic [identify_pkg::WORD_W-1:0] CYL_DEFAULT = identify_pkg::CYL_RESET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [identify_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [identify_pkg::WORD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [identify_pkg::WORD_W-1:0] reg_rdata,
    input wire logic id_start,
    input wire logic id_word_rd,
    output logic id_ready,
    output logic [identify_pkg::WORD_W-1:0] id_word,
    output logic [identify_pkg::IDX_W-1:0] id_word_index,
    output logic id_word_valid,
    output logic id_done
);
    import identify_pkg::*;

    typedef logic [STR_WORDS-1:0][WORD_W-1:0] str_store_t;

    typedef struct packed {
        xfer_state_e state;
        logic [IDX_W-1:0] idx;
        logic ready;
        logic [WORD_W-1:0] word;
        logic [IDX_W-1:0] word_index;
        logic word_valid;
        logic done;
        logic [WORD_W-1:0] rdata;
        logic [31:0] capacity;
        logic [WORD_W-1:0] cur_cyl;
        logic [WORD_W-1:0] mult;
        logic [2:0] mdma_sel;
        logic [WORD_W-1:0] sata_en;
        logic [WORD_W-1:0] cmd85_en;
        str_store_t str;
    } table_s;

    // Every string slot starts as two spaces, so unset strings read as blank.
    function automatic str_store_t blank_strings();
        str_store_t s;
        for (int i = 0; i < STR_WORDS; i++)
        begin
            s[i] = V_SPACES;
        end
        return s;
    endfunction

    function automatic table_s reset_state();
        table_s s;
        s.state = ST_IDLE;
        s.idx = '0;
        s.ready = 1'b0;
        s.word = V_ZERO;
        s.word_index = '0;
        s.word_valid = 1'b0;
        s.done = 1'b0;
        s.rdata = V_ZERO;
        s.capacity = CAP_RESET;
        s.cur_cyl = CYL_RESET;
        s.mult = MULT_RESET;
        s.mdma_sel = MDMA_RESET;
        s.sata_en = SATA_EN_RESET;
        s.cmd85_en = CMD85_EN_RESET;
        s.str = blank_strings();
        return s;
    endfunction

    table_s st_r;
    table_s st_nxt;
    logic [WORD_W-1:0] map_word;
    logic strap_loaded_r;
    logic [ADDR_W-1:0] str_off;

    ////////////////////////////////////////////////////////////////////////////

    identify_word_map u_map (
        .idx(st_r.idx),
        .capacity(st_r.capacity),
        .cur_cyl(st_r.cur_cyl),
        .mult(st_r.mult),
        .mdma_sel(st_r.mdma_sel),
        .sata_en(st_r.sata_en),
        .cmd85_en(st_r.cmd85_en),
        .str(st_r.str),
        .word(map_word)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_nxt = st_r;
        str_off = reg_addr - R_STR_BASE;
        st_nxt.word_valid = 1'b0;
        st_nxt.done = 1'b0;

        // The capacity defaults are parameters, so they are loaded once after
        // reset instead of being reset values taken from a port-like source.
        if (!strap_loaded_r)
        begin
            st_nxt.capacity = CAP_DEFAULT;
            st_nxt.cur_cyl = CYL_DEFAULT;
        end

        // Settings writes. A write during a transfer takes effect on the words
        // not yet read, which lets firmware adjust values live if it must.
        if (reg_wr)
        begin
            if (reg_addr == R_CAP_LO)
            begin
                st_nxt.capacity[15:0] = reg_wdata;
            end
            else if (reg_addr == R_CAP_HI)
            begin
                st_nxt.capacity[31:16] = reg_wdata;
            end
            else if (reg_addr == R_MULT)
            begin
                st_nxt.mult = reg_wdata & MULT_MASK;
            end
            else if (reg_addr == R_MDMA)
            begin
                st_nxt.mdma_sel = one_mode(reg_wdata[2:0]);
            end
            else if (reg_addr == R_SATA_EN)
            begin
                st_nxt.sata_en = reg_wdata & SATA_EN_MASK;
            end
            else if (reg_addr == R_CMD85_EN)
            begin
                st_nxt.cmd85_en = reg_wdata & CMD85_EN_MASK;
            end
            else if (reg_addr == R_CUR_CYL)
            begin
                st_nxt.cur_cyl = reg_wdata;
            end
            else if (reg_addr >= R_STR_BASE && str_off < ADDR_W'(STR_WORDS))
            begin
                st_nxt.str[str_off[STR_W-1:0]] = reg_wdata;
            end
        end

        // Read data stands for exactly the cycle after the read strobe.
        st_nxt.rdata = V_ZERO;
        if (reg_rd)
        begin
            if (reg_addr == R_STATUS)
            begin
                st_nxt.rdata = {6'h00, st_r.state, st_r.idx};
            end
            else if (reg_addr == R_CAP_LO)
            begin
                st_nxt.rdata = st_r.capacity[15:0];
            end
            else if (reg_addr == R_CAP_HI)
            begin
                st_nxt.rdata = st_r.capacity[31:16];
            end
            else if (reg_addr == R_MULT)
            begin
                st_nxt.rdata = st_r.mult;
            end
            else if (reg_addr == R_MDMA)
            begin
                st_nxt.rdata = WORD_W'(st_r.mdma_sel);
            end
            else if (reg_addr == R_SATA_EN)
            begin
                st_nxt.rdata = st_r.sata_en;
            end
            else if (reg_addr == R_CMD85_EN)
            begin
                st_nxt.rdata = st_r.cmd85_en;
            end
            else if (reg_addr == R_CUR_CYL)
            begin
                st_nxt.rdata = st_r.cur_cyl;
            end
            else if (reg_addr >= R_STR_BASE && str_off < ADDR_W'(STR_WORDS))
            begin
                st_nxt.rdata = st_r.str[str_off[STR_W-1:0]];
            end
        end

        // Read-out sequencer. A start during a transfer restarts from word 0,
        // since a new identify command abandons the old buffer.
        case (st_r.state)
            ST_IDLE:
            begin
                st_nxt.ready = 1'b0;
                if (id_start)
                begin
                    st_nxt.state = ST_PREP;
                    st_nxt.idx = '0;
                end
            end
            ST_PREP:
            begin
                st_nxt.state = ST_XFER;
                st_nxt.ready = 1'b1;
            end
            ST_XFER:
            begin
                if (id_start)
                begin
                    st_nxt.state = ST_PREP;
                    st_nxt.ready = 1'b0;
                    st_nxt.idx = '0;
                end
                else if (id_word_rd)
                begin
                    // Ascending order puts each low half ahead of its high half.
                    st_nxt.word = map_word;
                    st_nxt.word_index = st_r.idx;
                    st_nxt.word_valid = 1'b1;
                    st_nxt.idx = st_r.idx + 1'b1;
                    if (st_r.idx == LAST_IDX)
                    begin
                        st_nxt.state = ST_IDLE;
                        st_nxt.ready = 1'b0;
                        st_nxt.done = 1'b1;
                    end
                end
            end
            default:
            begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= reset_state();
            strap_loaded_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            strap_loaded_r <= 1'b1;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign id_ready = st_r.ready;
    assign id_word = st_r.word;
    assign id_word_index = st_r.word_index;
    assign id_word_valid = st_r.word_valid;
    assign id_done = st_r.done;

endmodule
`default_nettype wire

// file: testbench/identify_data_table_monitor.sv
/* Port checker for the identify generator.
 * Assumes one clock domain and a bind onto every generator instance. */
`timescale 1ns/10ps
`default_nettype none
module identify_data_table_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [identify_pkg::WORD_W-1:0] reg_rdata,
    input wire logic id_start,
    input wire logic id_word_rd,
    input wire logic id_ready,
    input wire logic [identify_pkg::WORD_W-1:0] id_word,
    input wire logic [identify_pkg::IDX_W-1:0] id_word_index,
    input wire logic id_word_valid,
    input wire logic id_done
);
    import identify_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    chk_ready_after_start: assert property (id_start |=> !id_ready ##1 id_ready)
        else $error("buffer not ready two cycles after start");
    chk_valid_after_read: assert property (id_word_rd && id_ready |=> id_word_valid)
        else $error("no word after accepted read");
    chk_no_stray_word: assert property (id_word_valid |-> $past(id_word_rd && id_ready))
        else $error("word without accepted read");
    chk_done_last: assert property (id_done |-> id_word_valid && id_word_index == 8'hFF)
        else $error("done not with last word");
    chk_done_drops: assert property (id_done |-> !id_ready)
        else $error("ready still high after last word");
    chk_word_holds: assert property (!id_word_valid |-> $stable(id_word))
        else $error("word changed without read");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_heads_word: assert property (id_word_valid && id_word_index == 8'h03 |-> id_word == 16'h0010)
        else $error("heads word wrong");
    chk_cmd83_word: assert property (id_word_valid && id_word_index == 8'h53 |-> id_word == 16'h7D08)
        else $error("word 83 wrong");
    chk_tail_zero: assert property (id_word_valid && id_word_index > 8'h55 |-> id_word == 16'h0000)
        else $error("reserved word not zero");
endmodule
bind identify_data_table identify_data_table_monitor u_identify_data_table_monitor (.ref_clk(ref_clk), .rst(rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .id_start(id_start), .id_word_rd(id_word_rd), .id_ready(id_ready),
    .id_word(id_word), .id_word_index(id_word_index), .id_word_valid(id_word_valid), .id_done(id_done));
`default_nettype wire

// file: testbench/identify_host.sv
/* Host controller model: starts an identify and reads every word it may.
 * Assumes go is a one-cycle pulse; slow leaves a gap between reads. */
`timescale 1ns/10ps
`default_nettype none
module identify_host (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic slow,
    input wire logic id_ready,
    input wire logic [identify_pkg::WORD_W-1:0] id_word,
    input wire logic [identify_pkg::IDX_W-1:0] id_word_index,
    input wire logic id_word_valid,
    input wire logic id_done,
    output logic id_start,
    output logic id_word_rd,
    output logic done
);
    import identify_pkg::*;
    logic [WORD_W-1:0] words [256];
    logic [8:0] cnt;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            id_start <= 1'b0;
            id_word_rd <= 1'b0;
            cnt <= 9'h000;
            done <= 1'b0;
        end
        else
        begin
            id_start <= go;
            // Reads stop at 256 so the model never strobes once ready falls.
            if (go)
            begin
                cnt <= 9'h000;
                done <= 1'b0;
                id_word_rd <= 1'b0;
            end
            else if (id_ready && cnt < 9'h100 && !(slow && id_word_rd))
            begin
                id_word_rd <= 1'b1;
                cnt <= cnt + 9'h001;
            end
            else
            begin
                id_word_rd <= 1'b0;
            end
            if (id_word_valid)
            begin
                words[id_word_index] <= id_word;
            end
            if (id_done)
            begin
                done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
/* Self-checking bench for the identify generator.
 * Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import identify_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    wire logic [15:0] reg_rdata, id_word;
    wire logic [7:0] id_word_index;
    wire logic id_start, id_word_rd, id_ready, id_word_valid, id_done, done;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] str_m [STR_WORDS];
    logic [31:0] cap_m;
    logic [15:0] mult_m, sata_m, cyl_m, c85_m;
    logic [2:0] sel_m;
    always #50 ref_clk = ~ref_clk;
    identify_data_table u_identify_data_table (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .id_start(id_start),
        .id_word_rd(id_word_rd), .id_ready(id_ready), .id_word(id_word), .id_word_index(id_word_index),
        .id_word_valid(id_word_valid), .id_done(id_done));
    identify_host u_identify_host (.ref_clk(ref_clk), .rst(rst), .go(go), .slow(slow), .id_ready(id_ready),
        .id_word(id_word), .id_word_index(id_word_index), .id_word_valid(id_word_valid), .id_done(id_done),
        .id_start(id_start), .id_word_rd(id_word_rd), .done(done));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    function automatic logic [15:0] exp_word(input int i);
        case (i)
            2: return 16'hC837;
            3: return 16'h0010;
            6: return 16'h003F;
            47: return 16'h8010;
            49: return 16'h2F00;
            50: return 16'h4000;
            53: return 16'h0007;
            54: return cyl_m;
            55: return 16'h0010;
            56: return 16'h003F;
            57, 60: return cap_m[15:0];
            58, 61: return cap_m[31:16];
            59: return mult_m;
            63: return {5'h00, sel_m, 8'h07};
            64: return 16'h0003;
            65, 66, 67, 68: return 16'h0078;
            75: return 16'h001F;
            76: return 16'h0106;
            78: return 16'h0044;
            79: return sata_m;
            80: return 16'h01F0;
            82: return 16'h746B;
            83: return 16'h7D08;
            84: return 16'h4040;
            85: return 16'h7468 | c85_m;
            default:
            begin
                if (i >= 10 && i <= 19)
                    return str_m[i-10];
                if (i >= 23 && i <= 46)
                    return str_m[i-13];
                return 16'h0000;
            end
        endcase
    endfunction
    task run_id(input logic s);
        int k;
        @(posedge ref_clk);
        go <= 1'b1;
        slow <= s;
        @(posedge ref_clk);
        go <= 1'b0;
        // The host clears its done flag on this edge; look only after it lands.
        @(posedge ref_clk);
        for (k = 0; k < 2000 && done !== 1'b1; k++)
            @(posedge ref_clk);
        check({15'h0000, done}, 16'h0001);
        for (k = 0; k < 256; k++)
            check(u_identify_host.words[k], exp_word(k));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int j = 0; j < STR_WORDS; j++)
            str_m[j] = 16'h2020;
        cap_m = CAP_RESET;
        mult_m = 16'h0110;
        sata_m = 16'h0040;
        sel_m = 3'h0;
        cyl_m = CYL_RESET;
        c85_m = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(R_MULT, 16'h0110);
        rd(R_SATA_EN, 16'h0040);
        rd(R_CAP_LO, CAP_RESET[15:0]);
        rd(8'h08, 16'h0000);
        run_id(1'b0);
        // Distinct characters per slot expose any swapped word or byte.
        for (int j = 0; j < STR_WORDS; j++)
        begin
            str_m[j] = {8'h41 + 8'(j), 8'h61 + 8'(j)};
            wr(R_STR_BASE + 8'(j), str_m[j]);
        end
        wr(R_CAP_LO, 16'h5678);
        wr(R_CAP_HI, 16'h1234);
        cap_m = 32'h1234_5678;
        wr(R_MULT, 16'hFFFF);
        mult_m = 16'h01FF;
        wr(R_SATA_EN, 16'hFFFF);
        sata_m = 16'h0044;
        wr(R_MDMA, 16'h0003);
        sel_m = 3'b010;
        wr(R_CMD85_EN, 16'hFFFF);
        c85_m = 16'h0003;
        wr(R_CUR_CYL, 16'h1357);
        cyl_m = 16'h1357;
        rd(R_MDMA, 16'h0002);
        rd(R_CAP_HI, 16'h1234);
        run_id(1'b1);
        wr(R_MDMA, 16'h0007);
        sel_m = 3'b100;
        run_id(1'b0);
        close_out();
    end
endmodule
`default_nettype wire
